// ### nma_defs.vh
/*
 * Constants for the oscillator modulus and alignment block: register
 * offsets, field positions, reset values and mode codes.
 * Assumes inclusion by nma_core.v only; holds definitions and nothing else.
 */
`ifndef NMA_DEFS_VH
`define NMA_DEFS_VH

// Register offsets on the byte-wide serial-port register space
`define NMA_ADDR_W            12
`define NMA_OFS_IRQ_EN        12'h021
`define NMA_OFS_IRQ_STAT      12'h025
`define NMA_OFS_ALIGN_CTRL    12'h050
`define NMA_OFS_KEY_I_LO      12'h051
`define NMA_OFS_KEY_I_HI      12'h052
`define NMA_OFS_KEY_Q_LO      12'h053
`define NMA_OFS_KEY_Q_HI      12'h054
`define NMA_OFS_TUNE_CTRL     12'h113
`define NMA_OFS_INT_B0        12'h114
`define NMA_OFS_INT_B5        12'h119
`define NMA_OFS_DEN_B0        12'h152
`define NMA_OFS_DEN_B5        12'h157
`define NMA_OFS_NUM_B0        12'h158
`define NMA_OFS_NUM_B5        12'h15D

// Field positions
`define NMA_BIT_ALIGN_IRQ     4
`define NMA_BIT_ARM           7
`define NMA_BIT_MATCH         5
`define NMA_BIT_PASS          4
`define NMA_BIT_FAIL          3
`define NMA_BIT_LOAD_REQ      0
`define NMA_BIT_LOAD_ACK      1

// Alignment mode codes in bits 1:0 of the alignment control register
`define NMA_MODE_SYSREF       2'h1
`define NMA_MODE_DATA_KEY     2'h2

// Widths and reset values
`define NMA_TW_W              48
`define NMA_KEY_W             16
`define NMA_RST_BYTE          8'h00
`define NMA_RST_KEY           16'h0000
`define NMA_RST_WORD          48'h0000_0000_0000

`endif

// ### nma_core.v
/*
 * Programmable-modulus oscillator accumulator with phase alignment by
 * SYSREF edge or by a data key at the converter input, plus its
 * serial-port register bank and alignment interrupt.
 * Assumes a byte-wide register port already decoded from the serial
 * interface, a SYSREF pin that is asynchronous to clock_i, and converter
 * input samples on clock_i.
 */
`timescale 1ns/1ns
`include "nma_defs.vh"

module nma_core (
  input  wire                      clock_i,
  input  wire                      rstn_i,
  input  wire [`NMA_ADDR_W-1:0]    reg_addr_i,
  input  wire [7:0]                reg_wdata_i,
  input  wire                      reg_wr_i,
  input  wire                      reg_rd_i,
  output reg  [7:0]                reg_rdata_o,
  input  wire                      sysref_i,
  input  wire                      subclass0_i,
  input  wire                      lmfc_oneshot_i,
  input  wire                      lmfc_armed_i,
  input  wire                      lmfc_align_ok_i,
  input  wire                      data_valid_i,
  input  wire [`NMA_KEY_W-1:0]     data_i_i,
  input  wire [`NMA_KEY_W-1:0]     data_q_i,
  output reg  [`NMA_TW_W-1:0]      phase_o,
  output reg                       align_pulse_o,
  output reg                       irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte k of a 48-bit word
  function [7:0] get_byte;
    input [`NMA_TW_W-1:0] word;
    input [2:0]           idx;
    begin
      get_byte = word[idx*8 +: 8];
    end
  endfunction

  // Replace byte k of a 48-bit word
  function [`NMA_TW_W-1:0] put_byte;
    input [`NMA_TW_W-1:0] word;
    input [2:0]           idx;
    input [7:0]           val;
    begin
      put_byte = word;
      put_byte[idx*8 +: 8] = val;
    end
  endfunction

  // Byte index of an address inside a six-byte group, 7 when outside
  function [2:0] grp_idx;
    input [`NMA_ADDR_W-1:0] addr;
    input [`NMA_ADDR_W-1:0] base;
    input [`NMA_ADDR_W-1:0] last;
    begin
      if (addr >= base && addr <= last) begin
        grp_idx = addr[2:0] - base[2:0];
      end else begin
        grp_idx = 3'h7;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Reset release and SYSREF synchroniser

  reg        rst_meta_ff;
  reg        rst_sync_ff;
  wire       rstn_s = rst_sync_ff;

  // Release reset through two flops
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  reg        sref_s1_ff;
  reg        sref_s2_ff;
  reg        sref_s3_ff;
  reg        sref_lvl_ff;
  wire       sref_agree = (sref_s2_ff == sref_s3_ff);
  wire       sref_rise  = sref_agree && sref_s3_ff && !sref_lvl_ff;

  // Three-flop synchroniser, level accepted once stages two and three agree
  always @(posedge clock_i or negedge rstn_s) begin
    if (!rstn_s) begin
      sref_s1_ff  <= 1'b0;
      sref_s2_ff  <= 1'b0;
      sref_s3_ff  <= 1'b0;
      sref_lvl_ff <= 1'b0;
    end else begin
      sref_s1_ff <= sysref_i;
      sref_s2_ff <= sref_s1_ff;
      sref_s3_ff <= sref_s2_ff;
      if (sref_agree) begin
        sref_lvl_ff <= sref_s3_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register bank state

  reg                    irq_en_ff;
  reg                    irq_stat_ff;
  reg                    arm_ff;
  reg                    match_ff;
  reg                    pass_ff;
  reg                    fail_ff;
  reg  [1:0]             mode_ff;
  reg  [`NMA_KEY_W-1:0]  key_i_ff;
  reg  [`NMA_KEY_W-1:0]  key_q_ff;
  reg                    load_req_ff;
  reg                    load_ack_ff;
  reg  [`NMA_TW_W-1:0]   int_wr_ff;   // Written integer part, not yet live
  reg  [`NMA_TW_W-1:0]   den_wr_ff;
  reg  [`NMA_TW_W-1:0]   num_wr_ff;
  reg  [`NMA_TW_W-1:0]   int_act_ff;  // Live values used by the accumulator
  reg  [`NMA_TW_W-1:0]   den_act_ff;
  reg  [`NMA_TW_W-1:0]   num_act_ff;

  wire [2:0] int_idx = grp_idx(reg_addr_i, `NMA_OFS_INT_B0, `NMA_OFS_INT_B5);
  wire [2:0] den_idx = grp_idx(reg_addr_i, `NMA_OFS_DEN_B0, `NMA_OFS_DEN_B5);
  wire [2:0] num_idx = grp_idx(reg_addr_i, `NMA_OFS_NUM_B0, `NMA_OFS_NUM_B5);

  wire wr_ctrl  = reg_wr_i && (reg_addr_i == `NMA_OFS_ALIGN_CTRL);
  wire wr_tune  = reg_wr_i && (reg_addr_i == `NMA_OFS_TUNE_CTRL);
  wire arm_wr1  = wr_ctrl && reg_wdata_i[`NMA_BIT_ARM];
  wire load_rise = wr_tune && reg_wdata_i[`NMA_BIT_LOAD_REQ] && !load_req_ff;

  ////////////////////////////////////////////////////////////////////////
  // Alignment triggers

  // SYSREF mode: subclass 0 trips on the next internal clock edge, else
  // the next SYSREF edge once the LMFC side is ready (armed in one-shot)
  wire sref_ok  = subclass0_i ||
                  (sref_rise && (!lmfc_oneshot_i || lmfc_armed_i));
  wire sys_trip = arm_ff && (mode_ff == `NMA_MODE_SYSREF) && sref_ok;
  wire key_seen = data_valid_i && (data_i_i == key_i_ff) && (data_q_i == key_q_ff);
  wire key_trip = arm_ff && (mode_ff == `NMA_MODE_DATA_KEY) && key_seen;
  wire trip     = sys_trip || key_trip;
  // SYSREF attempt outside subclass 0 counts as failed if the LMFC side did not lock
  wire sys_bad  = sys_trip && !subclass0_i && !lmfc_align_ok_i;
  // Armed with no valid mode selected is a failed attempt
  wire bad_mode = arm_ff && (mode_ff != `NMA_MODE_SYSREF) && (mode_ff != `NMA_MODE_DATA_KEY);

  ////////////////////////////////////////////////////////////////////////
  // Register writes, flags and tuning load

  always @(posedge clock_i or negedge rstn_s) begin
    if (!rstn_s) begin
      irq_en_ff   <= 1'b0;
      irq_stat_ff <= 1'b0;
      arm_ff      <= 1'b0;
      match_ff    <= 1'b0;
      pass_ff     <= 1'b0;
      fail_ff     <= 1'b0;
      mode_ff     <= 2'h0;
      key_i_ff    <= `NMA_RST_KEY;
      key_q_ff    <= `NMA_RST_KEY;
      load_req_ff <= 1'b0;
      load_ack_ff <= 1'b0;
      int_wr_ff   <= `NMA_RST_WORD;
      den_wr_ff   <= `NMA_RST_WORD;
      num_wr_ff   <= `NMA_RST_WORD;
      int_act_ff  <= `NMA_RST_WORD;
      den_act_ff  <= `NMA_RST_WORD;
      num_act_ff  <= `NMA_RST_WORD;
    end else begin
      // Plain byte registers
      if (reg_wr_i && reg_addr_i == `NMA_OFS_IRQ_EN) begin
        irq_en_ff <= reg_wdata_i[`NMA_BIT_ALIGN_IRQ];
      end
      if (reg_wr_i && reg_addr_i == `NMA_OFS_KEY_I_LO) begin
        key_i_ff[7:0] <= reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == `NMA_OFS_KEY_I_HI) begin
        key_i_ff[15:8] <= reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == `NMA_OFS_KEY_Q_LO) begin
        key_q_ff[7:0] <= reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == `NMA_OFS_KEY_Q_HI) begin
        key_q_ff[15:8] <= reg_wdata_i;
      end
      if (wr_ctrl) begin
        mode_ff <= reg_wdata_i[1:0];
      end
      // Tuning bytes land in the write copy only
      if (reg_wr_i && int_idx != 3'h7) begin
        int_wr_ff <= put_byte(int_wr_ff, int_idx, reg_wdata_i);
      end
      if (reg_wr_i && den_idx != 3'h7) begin
        den_wr_ff <= put_byte(den_wr_ff, den_idx, reg_wdata_i);
      end
      if (reg_wr_i && num_idx != 3'h7) begin
        num_wr_ff <= put_byte(num_wr_ff, num_idx, reg_wdata_i);
      end
      // Load request: copy to live and set the acknowledge in the same cycle, on its rising edge
      if (wr_tune) begin
        load_req_ff <= reg_wdata_i[`NMA_BIT_LOAD_REQ];
      end
      if (load_rise) begin
        int_act_ff  <= int_wr_ff;
        den_act_ff  <= den_wr_ff;
        num_act_ff  <= num_wr_ff;
        load_ack_ff <= 1'b1;
      end else if (wr_tune && !reg_wdata_i[`NMA_BIT_LOAD_REQ]) begin
        load_ack_ff <= 1'b0;
      end
      // Arm, trip and result flags; a fresh arm clears old results
      if (trip || bad_mode) begin
        arm_ff <= 1'b0;
      end else if (wr_ctrl) begin
        arm_ff <= reg_wdata_i[`NMA_BIT_ARM];
      end
      if (arm_wr1) begin
        match_ff <= 1'b0;
        pass_ff  <= 1'b0;
        fail_ff  <= 1'b0;
      end
      // A result landing in the arming cycle wins over the clear
      if (key_trip) begin
        match_ff <= 1'b1;
      end
      if (trip && !sys_bad) begin
        pass_ff <= 1'b1;
      end
      if (sys_bad || bad_mode) begin
        fail_ff <= 1'b1;
      end
      // Interrupt status: write one clears, a trip in the same cycle wins
      if (trip) begin
        irq_stat_ff <= 1'b1;
      end else if (reg_wr_i && reg_addr_i == `NMA_OFS_IRQ_STAT &&
                   reg_wdata_i[`NMA_BIT_ALIGN_IRQ]) begin
        irq_stat_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Modulus accumulator

  reg  [`NMA_TW_W-1:0] frac_ff;
  wire [`NMA_TW_W:0]   frac_sum  = {1'b0, frac_ff} + {1'b0, num_act_ff};
  wire                 frac_wrap = (den_act_ff != `NMA_RST_WORD) &&
                                   (frac_sum >= {1'b0, den_act_ff});
  wire [`NMA_TW_W:0]   frac_red  = frac_sum - {1'b0, den_act_ff};
  wire [`NMA_TW_W-1:0] nxt_frac  = (den_act_ff == `NMA_RST_WORD) ? `NMA_RST_WORD :
                                   frac_wrap ? frac_red[`NMA_TW_W-1:0] :
                                   frac_sum[`NMA_TW_W-1:0];
  // Two's complement integer step wraps naturally in 48 bits
  wire [`NMA_TW_W-1:0] nxt_phase = phase_o + int_act_ff +
                                   {{(`NMA_TW_W-1){1'b0}}, frac_wrap};

  // Phase and fraction advance each clock; a trip restarts both
  always @(posedge clock_i or negedge rstn_s) begin
    if (!rstn_s) begin
      frac_ff       <= `NMA_RST_WORD;
      phase_o       <= `NMA_RST_WORD;
      align_pulse_o <= 1'b0;
      irq_o         <= 1'b0;
    end else begin
      if (trip) begin
        frac_ff <= `NMA_RST_WORD;
        phase_o <= `NMA_RST_WORD;
      end else begin
        frac_ff <= nxt_frac;
        phase_o <= nxt_phase;
      end
      align_pulse_o <= trip;
      irq_o         <= irq_en_ff && (irq_stat_ff || trip);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read-back

  reg [7:0] nxt_rdata;

  // Read mux; unmapped addresses read zero
  always @* begin
    nxt_rdata = 8'h00;
    case (reg_addr_i)
      `NMA_OFS_IRQ_EN:     nxt_rdata[`NMA_BIT_ALIGN_IRQ] = irq_en_ff;
      `NMA_OFS_IRQ_STAT:   nxt_rdata[`NMA_BIT_ALIGN_IRQ] = irq_stat_ff;
      `NMA_OFS_ALIGN_CTRL: nxt_rdata = {arm_ff, 1'b0, match_ff, pass_ff, fail_ff, 1'b0, mode_ff};
      `NMA_OFS_KEY_I_LO:   nxt_rdata = key_i_ff[7:0];
      `NMA_OFS_KEY_I_HI:   nxt_rdata = key_i_ff[15:8];
      `NMA_OFS_KEY_Q_LO:   nxt_rdata = key_q_ff[7:0];
      `NMA_OFS_KEY_Q_HI:   nxt_rdata = key_q_ff[15:8];
      `NMA_OFS_TUNE_CTRL:  nxt_rdata = {6'h00, load_ack_ff, load_req_ff};
      default: begin
        if (int_idx != 3'h7) begin
          nxt_rdata = get_byte(int_wr_ff, int_idx);
        end else if (den_idx != 3'h7) begin
          nxt_rdata = get_byte(den_wr_ff, den_idx);
        end else if (num_idx != 3'h7) begin
          nxt_rdata = get_byte(num_wr_ff, num_idx);
        end
      end
    endcase
  end

  // Read data registered one cycle after the read strobe
  always @(posedge clock_i or negedge rstn_s) begin
    if (!rstn_s) begin
      reg_rdata_o <= `NMA_RST_BYTE;
    end else if (reg_rd_i) begin
      reg_rdata_o <= nxt_rdata;
    end
  end

endmodule // nma_core

// ### nma_chk.sv
/* Port checker for nma_core: alignment, interrupt and register read relations.
   Assumes it is bound to nma_core and sees only that module's ports. */
`timescale 1ns/1ns
module nma_chk (
  input wire logic        clock_i,
  input wire logic        rstn_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        sysref_i,
  input wire logic        subclass0_i,
  input wire logic        lmfc_oneshot_i,
  input wire logic        lmfc_armed_i,
  input wire logic [47:0] phase_o,
  input wire logic        align_pulse_o,
  input wire logic        irq_o
);
  logic [1:0] mode_ff;
  logic       arm_ff, en_ff, req_ff, ack_ff;
  ////////////////////////////////////////////////////////////
  // Shadow of control bits taken from register writes
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_ff <= 2'h0;
      arm_ff  <= 1'h0;
      en_ff   <= 1'h0;
      req_ff  <= 1'h0;
      ack_ff  <= 1'h0;
    end else begin
      if (reg_wr_i && reg_addr_i == 12'h050) begin
        mode_ff <= reg_wdata_i[1:0];
        arm_ff  <= reg_wdata_i[7];
      end else if (align_pulse_o || mode_ff == 2'h0 || mode_ff == 2'h3) begin
        arm_ff <= 1'h0;   // Trip or invalid mode disarms
      end
      if (reg_wr_i && reg_addr_i == 12'h021) en_ff <= reg_wdata_i[4];
      if (reg_wr_i && reg_addr_i == 12'h113) begin
        req_ff <= reg_wdata_i[0];
        ack_ff <= reg_wdata_i[0] & (ack_ff | ~req_ff);   // Set only on a 0-to-1 request
      end
    end
  end
  ////////////////////////////////////////////////////////////
  // Relations between the ports
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  sequence sys_rise_s;
    !sysref_i ##1 sysref_i;
  endsequence
  sequence sys_ready_s;
    arm_ff && mode_ff == 2'h1 && (!lmfc_oneshot_i || lmfc_armed_i);
  endsequence
  sysref_trip_a:
    assert property (sys_rise_s ##0 sys_ready_s |-> ##[2:7] align_pulse_o) else $error("no trip after sysref");
  sub0_trip_a:
    assert property ($rose(arm_ff) && mode_ff == 2'h1 && subclass0_i |-> ##1 align_pulse_o) else $error("no trip");
  disarmed_quiet_a:
    assert property (align_pulse_o |-> $past(arm_ff)) else $error("trip while disarmed");
  align_zero_a:
    assert property ($rose(align_pulse_o) |-> phase_o == 48'h0) else $error("phase not cleared");
  irq_follow_a:
    assert property (align_pulse_o && $past(en_ff) |-> irq_o) else $error("interrupt missing");
  irq_masked_a:
    assert property (!$past(en_ff) |-> !irq_o) else $error("interrupt while disabled");
  load_ack_a:
    assert property (reg_rd_i && reg_addr_i == 12'h113 |=> reg_rdata_o[1:0] == {$past(ack_ff), $past(req_ff)})
      else $error("load status wrong");
  mode_read_a:
    assert property (reg_rd_i && reg_addr_i == 12'h050 |=> reg_rdata_o[1:0] == $past(mode_ff)) else $error("mode wrong");
endmodule // nma_chk

// ### nma_src.sv
/* Far-end model: converter sample source and SYSREF generator.
   Assumes the bench calls its tasks from the main sequence. */
`timescale 1ns/1ns
module nma_src (
  input  wire logic        clock_i,
  output logic             sysref_o,
  output logic             valid_o,
  output logic [15:0]      i_o,
  output logic [15:0]      q_o
);
  logic        send_ff = 1'h0;
  logic [15:0] ki, kq;
  initial begin
    sysref_o = 1'h0;
    valid_o = 1'h0;
    i_o = 16'h0000;
    q_o = 16'h0000;
  end
  ////////////////////////////////////////////////////////////
  // One key frame on request, else invalid data that changes every cycle
  always @(negedge clock_i) begin
    valid_o <= send_ff;
    i_o <= send_ff ? ki : i_o + 16'h3a5b;
    q_o <= send_ff ? kq : ~q_o;
    send_ff <= 1'h0;
  end
  task send_key(input logic [15:0] i, input logic [15:0] q);
    @(posedge clock_i);
    ki = i;
    kq = q;
    send_ff = 1'h1;
    @(posedge clock_i);
  endtask
  // SYSREF idles low; a pulse gives one rising edge
  task pulse_sysref(input int len);
    @(negedge clock_i);
    sysref_o = 1'h1;
    repeat (len) @(negedge clock_i);
    sysref_o = 1'h0;
  endtask
endmodule // nma_src

// ### testbench.sv
/* Self-checking bench for nma_core with the sample source model and port checker.
   Assumes nma_core, nma_src and nma_chk are compiled first. */
`timescale 1ns/1ns
module testbench;
  logic        clock_i = 1'h0, rstn_i = 1'h0, reg_wr_i = 1'h0, reg_rd_i = 1'h0, seen;
  logic        subclass0_i = 1'h0, lmfc_oneshot_i = 1'h0, lmfc_armed_i = 1'h0, lmfc_align_ok_i = 1'h1;
  logic [11:0] reg_addr_i = 12'h000;
  logic [7:0]  reg_wdata_i = 8'h00, reg_rdata_o;
  logic [47:0] phase_o, x_w, ph;
  logic        align_pulse_o, irq_o, sysref_i, data_valid_i;
  logic [15:0] data_i_i, data_q_i, a_w, b_w, f_w, k_i, k_q;
  logic [31:0] seed = 32'hf5d2_a72e;
  int          n_fail = 0, num_checks = 0;
  always #2 clock_i = ~clock_i;
  nma_core i_nma_core (.clock_i(clock_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .sysref_i(sysref_i),
    .subclass0_i(subclass0_i), .lmfc_oneshot_i(lmfc_oneshot_i), .lmfc_armed_i(lmfc_armed_i),
    .lmfc_align_ok_i(lmfc_align_ok_i), .data_valid_i(data_valid_i), .data_i_i(data_i_i), .data_q_i(data_q_i),
    .phase_o(phase_o), .align_pulse_o(align_pulse_o), .irq_o(irq_o));
  nma_src i_nma_src (.clock_i(clock_i), .sysref_o(sysref_i), .valid_o(data_valid_i), .i_o(data_i_i), .q_o(data_q_i));
  ////////////////////////////////////////////////////////////
  // Random source, comparisons, register cycles and the reference phase model
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk_phase(input string nm, input logic [47:0] e, input logic [47:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clock_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'h1;
    @(negedge clock_i);
    reg_wr_i = 1'h0;
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e);
    @(negedge clock_i);
    reg_addr_i = a;
    reg_rd_i = 1'h1;
    @(negedge clock_i);
    reg_rd_i = 1'h0;
    chk_reg("register read", e, reg_rdata_o);
  endtask
  task wait_pulse(input logic exp);
    seen = 1'h0;
    for (int n = 0; n < 16 && !seen; n++) begin
      @(negedge clock_i);
      seen = align_pulse_o === 1'h1;
    end
    chk_reg("align pulse", {7'h00, exp}, {7'h00, seen});
  endtask
  // One clock of the modulus accumulator: wrap of the fraction carries one unit
  task step;
    f_w = f_w + a_w;
    ph = ph + x_w + ((f_w >= b_w) ? 48'h1 : 48'h0);
    if (f_w >= b_w) f_w = f_w - b_w;
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (12) @(negedge clock_i);
    rstn_i = 1'h1;
    repeat (3) @(negedge clock_i);
    rd(12'h050, 8'h00);
    rd(12'h021, 8'h00);
    wr(12'h0ff, 8'h5a);
    rd(12'h0ff, 8'h00);
    x_w = {16'(xs()), xs()};
    b_w = 16'(xs() % 250) | 16'h0003;
    a_w = 16'(xs() % b_w);
    for (int k = 0; k < 6; k++) begin
      wr(12'h114 + 12'(k), x_w[8*k +: 8]);
      wr(12'h152 + 12'(k), k == 0 ? b_w[7:0] : 8'h00);
      wr(12'h158 + 12'(k), k == 0 ? a_w[7:0] : 8'h00);
      rd(12'h114 + 12'(k), x_w[8*k +: 8]);
      rd(12'h152 + 12'(k), k == 0 ? b_w[7:0] : 8'h00);
      rd(12'h158 + 12'(k), k == 0 ? a_w[7:0] : 8'h00);
    end
    chk_phase("phase before load", 48'h0, phase_o);
    wr(12'h113, 8'h01);
    rd(12'h113, 8'h03);
    wr(12'h113, 8'h01);
    rd(12'h113, 8'h03);
    wr(12'h113, 8'h00);
    rd(12'h113, 8'h00);
    subclass0_i = 1'h1;
    wr(12'h050, 8'h81);
    wait_pulse(1'h1);
    ph = 48'h0;
    f_w = 16'h0000;
    for (int n = 0; n < 24; n++) begin
      chk_phase("phase", ph, phase_o);
      step();
      @(negedge clock_i);
    end
    subclass0_i = 1'h0;
    rd(12'h050, 8'h11);
    lmfc_oneshot_i = 1'h1;
    wr(12'h050, 8'h81);
    i_nma_src.pulse_sysref(2);
    wait_pulse(1'h0);
    rd(12'h050, 8'h81);
    lmfc_armed_i = 1'h1;
    i_nma_src.pulse_sysref(2);
    wait_pulse(1'h1);
    rd(12'h050, 8'h11);
    lmfc_oneshot_i = 1'h0;
    lmfc_align_ok_i = 1'h0;
    wr(12'h050, 8'h81);
    i_nma_src.pulse_sysref(2);
    wait_pulse(1'h1);
    rd(12'h050, 8'h09);
    for (int m = 0; m < 4; m += 3) begin
      wr(12'h050, 8'h80 | 8'(m));
      rd(12'h050, 8'h08 | 8'(m));
    end
    wr(12'h025, 8'h10);
    rd(12'h025, 8'h00);
    wr(12'h021, 8'h10);
    k_i = 16'(xs());
    k_q = 16'(xs());
    for (int k = 0; k < 4; k++) begin
      wr(12'h051 + 12'(k), k[1] ? k_q[8*k[0] +: 8] : k_i[8*k[0] +: 8]);
      rd(12'h051 + 12'(k), k[1] ? k_q[8*k[0] +: 8] : k_i[8*k[0] +: 8]);
    end
    wr(12'h050, 8'h02);
    i_nma_src.send_key(k_i, k_q);
    wait_pulse(1'h0);
    wr(12'h050, 8'h82);
    i_nma_src.send_key(k_i, k_q);
    wait_pulse(1'h1);
    chk_reg("interrupt", 8'h01, {7'h00, irq_o});
    rd(12'h050, 8'h32);
    rd(12'h025, 8'h10);
    wr(12'h025, 8'h10);
    rd(12'h025, 8'h00);
    chk_reg("interrupt", 8'h00, {7'h00, irq_o});
    wrap_up();
  end
endmodule // testbench
bind nma_core nma_chk i_nma_chk (.clock_i(clock_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .sysref_i(sysref_i), .subclass0_i(subclass0_i), .lmfc_oneshot_i(lmfc_oneshot_i), .lmfc_armed_i(lmfc_armed_i),
  .phase_o(phase_o), .align_pulse_o(align_pulse_o), .irq_o(irq_o));
